// File: sfpr_pkg.sv
// Purpose: Constants for the sector FIFO pointer block
// Assumes: 14-bit pointers, 8-bit register read port
// Notes:   Offsets are XDATA addresses of the read-only pointer bytes
package sfpr_pkg;
	// ****************************************
	// Widths and addresses
	// ****************************************
	localparam int PTR_W = 14;
	localparam logic [15:0] ADDR_CWP_LOW  = 16'hf0ed;
	localparam logic [15:0] ADDR_CWP_HIGH = 16'hf0ee;
	localparam logic [15:0] ADDR_CRP_LOW  = 16'hf0ef;
	localparam logic [15:0] ADDR_CRP_HIGH = 16'hf0f0;
	localparam logic [15:0] ADDR_BRP_LOW  = 16'hf0f1;
	localparam logic [15:0] ADDR_BRP_HIGH = 16'hf0f2;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [13:0] PTR_RST  = 14'h0000;
	localparam logic [7:0]  DATA_RST = 8'h00;
	// Flags out of reset: nothing confirmed, so nothing to read
	localparam logic        ALLOWED_RST = 1'h0;
	localparam logic        EMPTY_RST   = 1'h1;
endpackage : sfpr_pkg

// File: sfpr_sector_fifo_pointer_regs.sv
// Purpose: Write/read pointer management of the sector FIFO with backups
// Assumes: One clock, synchronous active-high reset, event pulses one cycle
// Notes:   Register bytes are read-only; reserved bits read as zero
`timescale 1ns/100ps

module sfpr_sector_fifo_pointer_regs (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// USB side write events
	input  wire logic        usb_write_strobe,
	input  wire logic        usb_write_confirm,
	input  wire logic        usb_write_crc_error,
	// Read events
	input  wire logic        usb_read_strobe,
	input  wire logic        usb_packet_acked,
	input  wire logic        usb_ack_timeout,
	input  wire logic        ata_read_strobe,
	// Register read port
	input  wire logic [15:0] reg_addr,
	// Status and data
	output logic [7:0]       reg_rdata,
	output logic [13:0]      current_write_position,
	output logic [13:0]      current_read_position,
	output logic             read_allowed,
	output logic             fifo_empty
);
	// ****************************************
	// Pointer state
	// ****************************************
	logic [13:0] cwp_ff;
	logic [13:0] confirmed_write_position_ff;
	logic [13:0] crp_ff;
	logic [13:0] backup_read_position_ff;
	logic [7:0]  rdata_ff;
	logic [13:0] nxt_cwp;
	logic [13:0] nxt_confirmed;
	logic [13:0] nxt_crp;
	logic [13:0] nxt_backup;
	logic        can_read;
	logic        usb_rd_ok;
	logic        ata_rd_ok;

	function automatic logic [13:0] ptr_inc(input logic [13:0] p);
		ptr_inc = p + 14'h0001;
	endfunction : ptr_inc

	// Reading stops at the confirmed point, not at the live write pointer
	assign can_read  = (crp_ff != confirmed_write_position_ff);
	assign usb_rd_ok = usb_read_strobe & can_read;
	// ATA read loses a same-cycle clash: it could not be rewound if it won
	assign ata_rd_ok = ata_read_strobe & can_read & ~usb_read_strobe;

	// ****************************************
	// Write side
	// ****************************************
	always_comb begin
		nxt_cwp = cwp_ff;
		if (usb_write_crc_error) begin
			nxt_cwp = confirmed_write_position_ff;
		end else if (usb_write_strobe) begin
			nxt_cwp = ptr_inc(cwp_ff);
		end
	end

	// A confirm in the same cycle as a CRC error is ignored: data is bad
	always_comb begin
		nxt_confirmed = confirmed_write_position_ff;
		if (usb_write_confirm && !usb_write_crc_error) begin
			nxt_confirmed = cwp_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cwp_ff                      <= sfpr_pkg::PTR_RST;
			confirmed_write_position_ff <= sfpr_pkg::PTR_RST;
		end else begin
			cwp_ff                      <= nxt_cwp;
			confirmed_write_position_ff <= nxt_confirmed;
		end
	end

	// ****************************************
	// Read side
	// ****************************************
	always_comb begin
		nxt_crp    = crp_ff;
		nxt_backup = backup_read_position_ff;
		if (usb_ack_timeout) begin
			nxt_crp = backup_read_position_ff;
		end else if (usb_rd_ok) begin
			nxt_crp = ptr_inc(crp_ff);
		end else if (ata_rd_ok) begin
			nxt_crp    = ptr_inc(crp_ff);
			nxt_backup = ptr_inc(crp_ff);
		end
		if (usb_packet_acked && !usb_ack_timeout) begin
			nxt_backup = crp_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			crp_ff                  <= sfpr_pkg::PTR_RST;
			backup_read_position_ff <= sfpr_pkg::PTR_RST;
		end else begin
			crp_ff                  <= nxt_crp;
			backup_read_position_ff <= nxt_backup;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_ff <= sfpr_pkg::DATA_RST;
		end else begin
			unique case (reg_addr)
				sfpr_pkg::ADDR_CWP_LOW:
					rdata_ff <= confirmed_write_position_ff[7:0];
				sfpr_pkg::ADDR_CWP_HIGH:
					rdata_ff <= {2'h0, confirmed_write_position_ff[13:8]};
				sfpr_pkg::ADDR_CRP_LOW:
					rdata_ff <= crp_ff[7:0];
				sfpr_pkg::ADDR_CRP_HIGH:
					rdata_ff <= {2'h0, crp_ff[13:8]};
				sfpr_pkg::ADDR_BRP_LOW:
					rdata_ff <= backup_read_position_ff[7:0];
				sfpr_pkg::ADDR_BRP_HIGH:
					rdata_ff <= {2'h0, backup_read_position_ff[13:8]};
				default:
					rdata_ff <= sfpr_pkg::DATA_RST;
			endcase
		end
	end

	logic [13:0] cwp_out_ff;
	logic [13:0] crp_out_ff;
	logic        allowed_ff;
	logic        empty_ff;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cwp_out_ff <= sfpr_pkg::PTR_RST;
			crp_out_ff <= sfpr_pkg::PTR_RST;
			allowed_ff <= sfpr_pkg::ALLOWED_RST;
			empty_ff   <= sfpr_pkg::EMPTY_RST;
		end else begin
			cwp_out_ff <= nxt_cwp;
			crp_out_ff <= nxt_crp;
			allowed_ff <= (nxt_crp != nxt_confirmed);
			empty_ff   <= (nxt_crp == nxt_cwp);
		end
	end

	assign reg_rdata              = rdata_ff;
	assign current_write_position = cwp_out_ff;
	assign current_read_position  = crp_out_ff;
	assign read_allowed           = allowed_ff;
	assign fifo_empty             = empty_ff;

	// ****************************************
	// Checks
	// ****************************************
	confirm_copy_a: assert property (@(posedge clk)
		disable iff (sys_rst) usb_write_confirm && !usb_write_crc_error
		|=> confirmed_write_position_ff == $past(cwp_ff))
		else $error("confirm did not copy write position");
	crc_rewind_a: assert property (@(posedge clk)
		disable iff (sys_rst) usb_write_crc_error
		|=> cwp_ff == $past(confirmed_write_position_ff))
		else $error("crc error did not rewind write position");
	crc_wins_a: assert property (@(posedge clk)
		disable iff (sys_rst) usb_write_crc_error
		|=> confirmed_write_position_ff == $past(confirmed_write_position_ff))
		else $error("confirm taken despite crc error");
	no_overread_a: assert property (@(posedge clk)
		disable iff (sys_rst)
		!usb_ack_timeout && crp_ff == confirmed_write_position_ff
		|=> crp_ff == $past(crp_ff))
		else $error("read passed confirmed position");
	allowed_flag_a: assert property (@(posedge clk)
		disable iff (sys_rst) read_allowed == (crp_ff != confirmed_write_position_ff))
		else $error("read allowed flag wrong");
	empty_flag_a: assert property (@(posedge clk)
		disable iff (sys_rst) fifo_empty == (crp_ff == cwp_ff))
		else $error("empty flag wrong");
	ack_backup_a: assert property (@(posedge clk)
		disable iff (sys_rst) usb_packet_acked && !usb_ack_timeout
		|=> backup_read_position_ff == $past(crp_ff))
		else $error("ack did not save read position");
	timeout_rewind_a: assert property (@(posedge clk)
		disable iff (sys_rst) usb_ack_timeout
		|=> crp_ff == $past(backup_read_position_ff))
		else $error("timeout did not rewind read position");
	timeout_wins_a: assert property (@(posedge clk)
		disable iff (sys_rst) usb_ack_timeout
		|=> backup_read_position_ff == $past(backup_read_position_ff))
		else $error("backup moved during timeout");
	ata_track_a: assert property (@(posedge clk)
		disable iff (sys_rst) ata_rd_ok && !usb_ack_timeout && !usb_packet_acked
		|=> crp_ff == $past(crp_ff) + 14'h0001 && backup_read_position_ff == crp_ff)
		else $error("backup did not track ata read");
	read_clash_a: assert property (@(posedge clk)
		disable iff (sys_rst)
		usb_rd_ok && ata_read_strobe && !usb_ack_timeout && !usb_packet_acked
		|=> backup_read_position_ff == $past(backup_read_position_ff))
		else $error("ata read taken in a clash");
	high_byte_a: assert property (@(posedge clk)
		disable iff (sys_rst) reg_addr == sfpr_pkg::ADDR_CWP_HIGH
		|=> reg_rdata == {2'h0, $past(confirmed_write_position_ff[13:8])})
		else $error("confirmed high byte wrong");
	read_low_a: assert property (@(posedge clk)
		disable iff (sys_rst) reg_addr == sfpr_pkg::ADDR_CRP_LOW
		|=> reg_rdata == $past(crp_ff[7:0]))
		else $error("read low byte wrong");
	read_high_a: assert property (@(posedge clk)
		disable iff (sys_rst) reg_addr == sfpr_pkg::ADDR_CRP_HIGH
		|=> reg_rdata[7:6] == 2'h0 && reg_rdata[5:0] == $past(crp_ff[13:8]))
		else $error("read high byte wrong");
endmodule : sfpr_sector_fifo_pointer_regs

// File: sfpr_far_model.sv
// Purpose: Far-side model issuing FIFO event pulses
// Assumes: Pulses driven at the falling edge, one cycle wide
// Notes:   A gap cycle between pulses keeps each event distinct
`timescale 1ns/100ps
module sfpr_far_model (
	// Clock
	input  wire logic clk,
	// Events: write, confirm, crc, usb read, ack, timeout, ata read
	output logic [6:0] ev
);
	// ****************************************
	// Event bursts
	// ****************************************
	initial ev = 7'h00;
	task automatic burst(input int code, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk) ev[code] = 1'h1;
			@(negedge clk) ev[code] = 1'h0;
		end
	endtask : burst
	// Several events in one cycle, to exercise the priority choices
	task automatic pulse(input logic [6:0] m);
		@(negedge clk) ev = m;
		@(negedge clk) ev = 7'h00;
	endtask : pulse
endmodule : sfpr_far_model

// File: sfpr_sector_fifo_pointer_regs_tb.sv
// Purpose: Self-checking bench of the sector FIFO pointer block
// Assumes: Register data is valid one cycle after the address is set
// Notes:   Long bursts push pointers past 255 to reach the high bytes
`timescale 1ns/100ps
module sfpr_sector_fifo_pointer_regs_tb;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk      = 1'h0;
	logic        sys_rst  = 1'h1;
	logic [15:0] reg_addr = 16'h0000;
	logic [6:0]  ev;
	logic [7:0]  reg_rdata;
	logic [13:0] cwp;
	logic [13:0] crp;
	logic        rd_ok;
	logic        empty;
	int          miscompares  = 0;
	int          total_checks = 0;
	int          cycles       = 0;
	always #12.5 clk = ~clk;
	sfpr_far_model u_far (.clk(clk), .ev(ev));
	sfpr_sector_fifo_pointer_regs DUT (.clk(clk), .sys_rst(sys_rst),
		.usb_write_strobe(ev[0]), .usb_write_confirm(ev[1]),
		.usb_write_crc_error(ev[2]), .usb_read_strobe(ev[3]),
		.usb_packet_acked(ev[4]), .usb_ack_timeout(ev[5]),
		.ata_read_strobe(ev[6]), .reg_addr(reg_addr),
		.reg_rdata(reg_rdata), .current_write_position(cwp),
		.current_read_position(crp), .read_allowed(rd_ok),
		.fifo_empty(empty));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_of_test();
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk) reg_addr = a;
		@(negedge clk) check({8'h00, reg_rdata}, {8'h00, e});
	endtask : rd
	// Hang guard, well above the roughly 1200 cycles of the run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			end_of_test();
		end
	end
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (4) @(negedge clk);
		sys_rst = 1'h0;
		check({15'h0000, empty}, 16'h0001);
		rd(16'hf0ee, 8'h00);
		rd(16'hf0ef, 8'h00);
		rd(16'hf0f0, 8'h00);
		rd(16'h1234, 8'h00);
		u_far.burst(0, 3);
		check({15'h0000, empty}, 16'h0000);
		u_far.burst(3, 1);
		check({2'h0, crp}, 16'h0000);
		check({15'h0000, rd_ok}, 16'h0000);
		u_far.burst(1, 1);
		rd(16'hf0ed, 8'h03);
		check({15'h0000, rd_ok}, 16'h0001);
		u_far.burst(3, 2);
		u_far.burst(4, 1);
		rd(16'hf0f1, 8'h02);
		u_far.burst(3, 2);
		check({2'h0, crp}, 16'h0003);
		u_far.burst(5, 1);
		check({2'h0, crp}, 16'h0002);
		// Ack and timeout together: the rewind wins, backup stays
		u_far.burst(3, 1);
		u_far.pulse(7'h30);
		check({2'h0, crp}, 16'h0002);
		rd(16'hf0f1, 8'h02);
		u_far.burst(0, 2);
		u_far.burst(2, 1);
		check({2'h0, cwp}, 16'h0003);
		// Confirm with a CRC error: the bad data is never confirmed
		u_far.burst(0, 2);
		u_far.pulse(7'h06);
		check({2'h0, cwp}, 16'h0003);
		rd(16'hf0ed, 8'h03);
		u_far.burst(0, 300);
		u_far.burst(1, 1);
		rd(16'hf0ee, 8'h01);
		u_far.burst(6, 257);
		rd(16'hf0f0, 8'h01);
		rd(16'hf0ef, 8'h03);
		rd(16'hf0f2, 8'h01);
		// USB and ATA read together: only the USB read is taken
		u_far.pulse(7'h48);
		check({2'h0, crp}, 16'h0104);
		rd(16'hf0f1, 8'h03);
		u_far.burst(5, 1);
		check({2'h0, crp}, 16'h0103);
		end_of_test();
	end
endmodule : sfpr_sector_fifo_pointer_regs_tb
